// ==== src/core_regs_pkg.sv ====
// Shared constants and carriers for the core architectural register set.
// Assumes a single core clock and an instruction sequencer outside this block.
package core_regs_pkg;

  // Special register addresses
  localparam logic [7:0] ADDR_STACK = 8'h81;       // Stack top pointer
  localparam logic [7:0] ADDR_PTR_LOW = 8'h82;     // Memory pointer low byte
  localparam logic [7:0] ADDR_PTR_HIGH = 8'h83;    // Memory pointer high byte
  localparam logic [7:0] ADDR_PROG_CTRL = 8'h87;   // Core program control
  localparam logic [7:0] ADDR_PTR_SEL = 8'hA7;     // Active pointer select
  localparam logic [7:0] ADDR_POWER_CTRL = 8'hC5;  // Power control
  localparam logic [7:0] ADDR_FLAGS = 8'hD0;       // Status flags word
  localparam logic [7:0] ADDR_ACCUM = 8'hE0;       // Main operand register
  localparam logic [7:0] ADDR_MULAUX = 8'hF0;      // Multiply auxiliary register

  // Status flags word bit positions
  localparam int FLAG_CARRY = 7;
  localparam int FLAG_AUX = 6;
  localparam int FLAG_USER0 = 5;
  localparam int FLAG_BANK_HI = 4;
  localparam int FLAG_BANK_LO = 3;
  localparam int FLAG_OVF = 2;
  localparam int FLAG_USER1 = 1;
  localparam int FLAG_PARITY = 0;

  // Reset values
  localparam logic [15:0] RST_PC = 16'h0000;
  localparam logic [7:0] RST_STACK = 8'h07;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_OPCODE = 8'h00;
  localparam logic [15:0] RST_PTR = 16'h0000;

  // Execution cycle counts per operand kind
  localparam logic [1:0] CYC_BANK_OP = 2'h1;   // Accumulator with bank register
  localparam logic [1:0] CYC_OTHER_OP = 2'h2;  // Accumulator with literal or RAM byte

  // Storage sizes
  localparam int BANK_BYTES = 32;
  localparam int EXTENDED_RAM_BYTES = 256;

  // Stack operation request
  typedef enum logic [1:0] {STK_NONE, STK_PUSH, STK_POP} stack_op_t;

  // Program counter request
  typedef enum logic [1:0] {PC_HOLD, PC_STEP, PC_LOAD} pc_op_t;

  // Byte-wide special register access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  // Single-bit special register access
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [2:0] pos;
    logic val;
  } bit_req_t;

  // Arithmetic outcome from the ALU
  typedef struct packed {
    logic upd;
    logic carry;
    logic aux;
    logic ovf;
  } alu_flags_t;

endpackage : core_regs_pkg

// ==== src/core_register_set.sv ====
// Architectural register set of a single-cycle 8-bit controller core.
// Assumes the sequencer drives one request of each kind per cycle and
// that only on-chip code and data storage exist.
// Function
// - Program counter holds next fetch address, reset zero
// - Counter advances by instruction length one to three
// - Counter changed only by stepping, call, jump
// - Opcode latch holds current opcode, not software visible
// - Four banks of eight registers in low RAM
// - Bank operand one cycle, literal or RAM two
// - Bank chosen by two bits in flags word
// - Parity flag tracks accumulator continuously
// - Auxiliary register holds multiply/divide second operand
// - Carry, aux carry, overflow record ALU outcome
// - Flags word is bit addressable
// - Memory pointer usable as 16 or two 8-bit
// - Main and shadow pointers, active one used
// - Push increments pointer then writes
// - Pop reads then decrements pointer
// - Calls, returns, interrupts use stack for return address
// - Stack lives in extended RAM, zero is start
// - Program control register is byte access only
// - No external code or data memory path
// - Stack pointer resets to seven
// - Bank bits decode binary zero to three
`timescale 1ns/1ps

module core_register_set
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Program flow
  input wire core_regs_pkg::pc_op_t pc_op,
  input wire logic [1:0] instr_len,
  input wire logic [15:0] pc_target,
  input wire logic opcode_load,
  input wire logic [7:0] opcode_in,
  input wire logic [1:0] instr_kind,
  // Special register access
  input wire core_regs_pkg::sfr_req_t sfr_req,
  input wire core_regs_pkg::bit_req_t bit_req,
  // Accumulator and arithmetic results
  input wire logic acc_wr,
  input wire logic [7:0] acc_wdata,
  input wire core_regs_pkg::alu_flags_t alu_flags,
  input wire logic muldiv_wr,
  input wire logic [7:0] muldiv_aux_res,
  // Working register bank access
  input wire logic bank_wr,
  input wire logic [2:0] bank_idx,
  input wire logic [7:0] bank_wdata,
  // Stack and pointer use
  input wire core_regs_pkg::stack_op_t stack_op,
  input wire logic [7:0] stack_wdata,
  input wire logic ptr_inc,
  // Outputs
  output logic [15:0] program_counter,
  output logic [7:0] opcode_latch,
  output logic [7:0] sfr_rdata,
  output logic [7:0] bank_rdata,
  output logic [7:0] stack_rdata,
  output logic [15:0] active_pointer,
  output logic [7:0] muldiv_operand,
  output logic [1:0] exec_cycles
);

  import core_regs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [15:0] pc_q;                       // Next fetch address
  logic [7:0] opc_q;                       // Executing opcode
  logic [7:0] acc_q;                       // Main operand register
  logic [7:0] aux_q;                       // Multiply auxiliary register
  logic [7:0] flags_q;                     // Flags, parity bit unused here
  logic [7:0] sp_q;                        // Stack top pointer
  logic [7:0] prog_ctrl_q;                 // Byte-only control register
  logic [7:0] power_q;                     // Power control byte
  logic [15:0] ptr_q [2];                  // Main and shadow pointers
  logic ptr_sel_q;                         // Active pointer index
  logic [7:0] bank_mem [BANK_BYTES];       // Four banks of eight bytes
  logic [7:0] extended_ram [EXTENDED_RAM_BYTES];           // Stack storage
  logic [7:0] sfr_rdata_q;
  logic [7:0] bank_rdata_q;
  logic [7:0] stack_rdata_q;
  logic [1:0] cycles_q;
  logic parity;
  logic [1:0] bank_no;
  logic [4:0] bank_addr;
  logic [7:0] sp_inc;
  logic [7:0] flags_view;
  logic [15:0] ptr_d [2]; // Pointer next state
  logic ptr_sel_d; // Pointer select next state
  logic [15:0] act_ptr_q; // Registered copy of the active pointer

  // Parity is even across accumulator plus flag, so it is the xor
  assign parity = ^acc_q;
  // Bank bits form a binary bank number
  assign bank_no = {flags_q[FLAG_BANK_HI], flags_q[FLAG_BANK_LO]};
  assign bank_addr = {bank_no, bank_idx};
  assign sp_inc = 8'(sp_q + 8'h01);
  assign flags_view = {flags_q[7:1], parity};

  ////////////////////////////////////////////////////////////////////////////
  // Program counter: no software path, only step or branch
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      pc_q <= RST_PC;
    else
      case (pc_op)
        PC_STEP: pc_q <= 16'(pc_q + {14'h0000, instr_len});
        PC_LOAD: pc_q <= pc_target;
        default: pc_q <= pc_q;
      endcase
  end

  // Opcode latch, internal only
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      opc_q <= RST_OPCODE;
    else if (opcode_load)
      opc_q <= opcode_in;
  end

  // Cycle count: kind 0 is a bank operand, others literal or RAM
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      cycles_q <= CYC_BANK_OP;
    else
      cycles_q <= (instr_kind == 2'h0) ? CYC_BANK_OP : CYC_OTHER_OP;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      acc_q <= RST_BYTE;
    else if (acc_wr)
      acc_q <= acc_wdata;
    else if (sfr_req.wr && sfr_req.addr == ADDR_ACCUM)
      acc_q <= sfr_req.wdata;
  end

  // Auxiliary register: multiply result first, else scratch byte
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      aux_q <= RST_BYTE;
    else if (muldiv_wr)
      aux_q <= muldiv_aux_res;
    else if (sfr_req.wr && sfr_req.addr == ADDR_MULAUX)
      aux_q <= sfr_req.wdata;
  end

  // Flags word: byte write beats bit write, ALU outcome wins over both
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      flags_q <= RST_BYTE;
    else
    begin
      if (sfr_req.wr && sfr_req.addr == ADDR_FLAGS)
        flags_q <= sfr_req.wdata;
      else if (bit_req.wr && bit_req.addr == ADDR_FLAGS)
        flags_q[bit_req.pos] <= bit_req.val;
      if (alu_flags.upd)
      begin
        flags_q[FLAG_CARRY] <= alu_flags.carry;
        flags_q[FLAG_AUX] <= alu_flags.aux;
        flags_q[FLAG_OVF] <= alu_flags.ovf;
      end
    end
  end

  // Program and power control: byte writes only, bit writes ignored
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prog_ctrl_q <= RST_BYTE;
      power_q <= RST_BYTE;
    end
    else if (sfr_req.wr)
    begin
      if (sfr_req.addr == ADDR_PROG_CTRL)
        prog_ctrl_q <= sfr_req.wdata;
      if (sfr_req.addr == ADDR_POWER_CTRL)
        power_q <= sfr_req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pointer next state; a step in the cycle of a select write hits the old copy
  always_comb
  begin
    ptr_d[0] = ptr_q[0];
    ptr_d[1] = ptr_q[1];
    ptr_sel_d = ptr_sel_q;
    if (sfr_req.wr && sfr_req.addr == ADDR_PTR_SEL)
      ptr_sel_d = sfr_req.wdata[0];
    if (ptr_inc)
      ptr_d[ptr_sel_q] = 16'(ptr_q[ptr_sel_q] + 16'h0001);
    else if (sfr_req.wr && sfr_req.addr == ADDR_PTR_LOW)
      ptr_d[ptr_sel_q][7:0] = sfr_req.wdata;
    else if (sfr_req.wr && sfr_req.addr == ADDR_PTR_HIGH)
      ptr_d[ptr_sel_q][15:8] = sfr_req.wdata;
  end

  // Active copy is taken from the next state, so the output is a flop yet never lags
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ptr_q[0] <= RST_PTR;
      ptr_q[1] <= RST_PTR;
      ptr_sel_q <= 1'b0;
      act_ptr_q <= RST_PTR;
    end
    else
    begin
      ptr_q[0] <= ptr_d[0];
      ptr_q[1] <= ptr_d[1];
      ptr_sel_q <= ptr_sel_d;
      act_ptr_q <= ptr_d[ptr_sel_d];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stack pointer: pre-increment push, post-decrement pop, wraps at 256
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      sp_q <= RST_STACK;
    else if (stack_op == STK_PUSH)
      sp_q <= sp_inc;
    else if (stack_op == STK_POP)
      sp_q <= 8'(sp_q - 8'h01);
    else if (sfr_req.wr && sfr_req.addr == ADDR_STACK)
      sp_q <= sfr_req.wdata;
  end

  // Stack storage in extended RAM; the only data space beyond banks
  always_ff @(posedge clk)
  begin
    if (stack_op == STK_PUSH)
      extended_ram[sp_inc] <= stack_wdata;
  end

  // Pop data taken at the old top before the pointer moves
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      stack_rdata_q <= RST_BYTE;
    else if (stack_op == STK_POP)
      stack_rdata_q <= extended_ram[sp_q];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Working register banks in the low 32 RAM bytes
  always_ff @(posedge clk)
  begin
    if (bank_wr)
      bank_mem[bank_addr] <= bank_wdata;
  end

  // Bank read in the same cycle as the request, registered out
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      bank_rdata_q <= RST_BYTE;
    else
      bank_rdata_q <= bank_mem[bank_addr];
  end

  // Special register read mux; unmapped reads return zero
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      sfr_rdata_q <= RST_BYTE;
    else if (sfr_req.rd)
      case (sfr_req.addr)
        ADDR_ACCUM: sfr_rdata_q <= acc_q;
        ADDR_MULAUX: sfr_rdata_q <= aux_q;
        ADDR_FLAGS: sfr_rdata_q <= flags_view;
        ADDR_STACK: sfr_rdata_q <= sp_q;
        ADDR_PTR_LOW: sfr_rdata_q <= ptr_q[ptr_sel_q][7:0];
        ADDR_PTR_HIGH: sfr_rdata_q <= ptr_q[ptr_sel_q][15:8];
        ADDR_PTR_SEL: sfr_rdata_q <= {7'h00, ptr_sel_q};
        ADDR_PROG_CTRL: sfr_rdata_q <= prog_ctrl_q;
        ADDR_POWER_CTRL: sfr_rdata_q <= power_q;
        default: sfr_rdata_q <= 8'h00;
      endcase
  end

  // Outputs straight from flops
  assign program_counter = pc_q;
  assign opcode_latch = opc_q;
  assign sfr_rdata = sfr_rdata_q;
  assign bank_rdata = bank_rdata_q;
  assign stack_rdata = stack_rdata_q;
  assign active_pointer = act_ptr_q;
  assign muldiv_operand = aux_q;
  assign exec_cycles = cycles_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_pc_reset_zero: assert property (@(posedge clk) $rose(rstn) |-> pc_q == 16'h0000)
    else $error("pc not zero after reset");
  a_pc_step_len: assert property (@(posedge clk) disable iff (!rstn)
    pc_op == PC_STEP |=> pc_q == 16'($past(pc_q) + {14'h0000, $past(instr_len)}))
    else $error("pc step wrong");
  a_pc_hold_only: assert property (@(posedge clk) disable iff (!rstn)
    pc_op == PC_HOLD |=> $stable(pc_q))
    else $error("pc moved without request");
  a_push_pre_inc: assert property (@(posedge clk) disable iff (!rstn)
    stack_op == STK_PUSH |=> sp_q == 8'($past(sp_q) + 8'h01))
    else $error("push pointer wrong");
  a_pop_post_dec: assert property (@(posedge clk) disable iff (!rstn)
    stack_op == STK_POP |=> sp_q == 8'($past(sp_q) - 8'h01))
    else $error("pop pointer wrong");
  a_stack_lifo: assert property (@(posedge clk) disable iff (!rstn)
    stack_op == STK_PUSH ##1 stack_op == STK_POP |=> stack_rdata_q == $past(stack_wdata, 2))
    else $error("stack not lifo");
  a_parity_even: assert property (@(posedge clk) disable iff (!rstn)
    (sfr_req.rd && sfr_req.addr == ADDR_FLAGS)
      |=> ^{$past(acc_q), sfr_rdata_q[FLAG_PARITY]} == 1'b0)
    else $error("parity not even");
  a_ctrl_no_bit: assert property (@(posedge clk) disable iff (!rstn)
    (bit_req.wr && !sfr_req.wr) |=> $stable(prog_ctrl_q))
    else $error("control changed by bit write");
  a_cycles_kind: assert property (@(posedge clk) disable iff (!rstn)
    instr_kind == 2'h0 |=> cycles_q == CYC_BANK_OP)
    else $error("bank operand not one cycle");
  a_opcode_load: assert property (@(posedge clk) disable iff (!rstn)
    opcode_load |=> opc_q == $past(opcode_in))
    else $error("opcode not latched");
  a_alu_flags_win: assert property (@(posedge clk) disable iff (!rstn)
    alu_flags.upd |=> flags_q[FLAG_CARRY] == $past(alu_flags.carry)
      && flags_q[FLAG_AUX] == $past(alu_flags.aux)
      && flags_q[FLAG_OVF] == $past(alu_flags.ovf))
    else $error("alu flags lost");
  a_bit_flag_write: assert property (@(posedge clk) disable iff (!rstn)
    (bit_req.wr && bit_req.addr == ADDR_FLAGS && !sfr_req.wr && !alu_flags.upd)
      |=> flags_q[$past(bit_req.pos)] == $past(bit_req.val))
    else $error("flag bit write lost");
  a_ptr_inc_active: assert property (@(posedge clk) disable iff (!rstn)
    (ptr_inc && !(sfr_req.wr && sfr_req.addr == ADDR_PTR_SEL))
      |=> act_ptr_q == 16'($past(act_ptr_q) + 16'h0001))
    else $error("active pointer not stepped");
  a_stack_reset: assert property (@(posedge clk) $rose(rstn) |-> sp_q == 8'h07)
    else $error("stack pointer reset wrong");

endmodule : core_register_set

// ==== bench/tb_top.sv ====
// Self-checking bench for the core architectural register set.
// Assumes core_regs_pkg is compiled first; all inputs change on falling edges.
`timescale 1ns/1ps

module tb_top;
  import core_regs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Stimulus and observed signals
  logic clk; // Core clock, 5 ns
  logic rstn; // Async reset, active low
  pc_op_t pc_op;
  logic [1:0] instr_len;
  logic [15:0] pc_target;
  logic opcode_load;
  logic [7:0] opcode_in;
  logic [1:0] instr_kind;
  sfr_req_t sfr_req;
  bit_req_t bit_req;
  logic acc_wr;
  logic [7:0] acc_wdata;
  alu_flags_t alu_flags;
  logic muldiv_wr;
  logic [7:0] muldiv_aux_res;
  logic bank_wr;
  logic [2:0] bank_idx;
  logic [7:0] bank_wdata;
  stack_op_t stack_op;
  logic [7:0] stack_wdata;
  logic ptr_inc;
  logic [15:0] program_counter;
  logic [7:0] opcode_latch;
  logic [7:0] sfr_rdata;
  logic [7:0] bank_rdata;
  logic [7:0] stack_rdata;
  logic [15:0] active_pointer;
  logic [7:0] muldiv_operand;
  logic [1:0] exec_cycles;
  int miscompares; // Mismatches seen
  int n_compared; // Comparisons made
  logic [7:0] rb; // Last byte read back

`define CHK(nm, ex, gt) \
  begin \
    n_compared++; \
    if ((gt) !== (ex)) \
    begin \
      miscompares++; \
      $display("BAD %s expected %h seen %h", nm, ex, gt); \
    end \
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Device under test
  core_register_set i_dut (.clk(clk), .rstn(rstn), .pc_op(pc_op), .instr_len(instr_len),
    .pc_target(pc_target), .opcode_load(opcode_load), .opcode_in(opcode_in),
    .instr_kind(instr_kind), .sfr_req(sfr_req), .bit_req(bit_req), .acc_wr(acc_wr),
    .acc_wdata(acc_wdata), .alu_flags(alu_flags), .muldiv_wr(muldiv_wr),
    .muldiv_aux_res(muldiv_aux_res), .bank_wr(bank_wr), .bank_idx(bank_idx),
    .bank_wdata(bank_wdata), .stack_op(stack_op), .stack_wdata(stack_wdata),
    .ptr_inc(ptr_inc), .program_counter(program_counter), .opcode_latch(opcode_latch),
    .sfr_rdata(sfr_rdata), .bank_rdata(bank_rdata), .stack_rdata(stack_rdata),
    .active_pointer(active_pointer), .muldiv_operand(muldiv_operand),
    .exec_cycles(exec_cycles));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, free running
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // The wr, rd and stk tasks end with an idle edge so no strobe is set twice in one step
  task automatic tick();
    @(negedge clk);
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    tick();
    sfr_req = '0;
    tick();
  endtask : wr

  // Read data is registered, so it is taken one edge after the request
  task automatic rd(input logic [7:0] a);
    sfr_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    tick();
    sfr_req = '0;
    rb = sfr_rdata;
    tick();
  endtask : rd

  task automatic stk(input stack_op_t op, input logic [7:0] d);
    stack_op = op;
    stack_wdata = d;
    tick();
    stack_op = STK_NONE;
    tick();
  endtask : stk

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results

  // Watchdog: the tests need about a hundred cycles, allow forty times more
  initial
  begin
    #20000;
    miscompares++;
    $display("watchdog expired");
    results();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial
  begin
    rstn = 1'b0;
    pc_op = PC_HOLD; instr_len = 2'd1; pc_target = 16'h0000; opcode_load = 1'b0;
    opcode_in = 8'h00; instr_kind = 2'd0; sfr_req = '0; bit_req = '0; acc_wr = 1'b0;
    acc_wdata = 8'h00; alu_flags = '0; muldiv_wr = 1'b0; muldiv_aux_res = 8'h00;
    bank_wr = 1'b0; bank_idx = 3'd0; bank_wdata = 8'h00; stack_op = STK_NONE;
    stack_wdata = 8'h00; ptr_inc = 1'b0; miscompares = 0; n_compared = 0;
    repeat (2) @(posedge clk);
    tick();
    rstn = 1'b1;
    tick();
    // Reset values
    `CHK("pc", 16'h0000, program_counter)
    rd(ADDR_STACK);
    `CHK("sp", 8'h07, rb)
    `CHK("ptr", 16'h0000, active_pointer)
    $display("reset test done");
    // Program counter steps by length, then loads a target
    for (int n = 1; n <= 3; n++)
    begin
      pc_op = PC_STEP; instr_len = 2'(n);
      tick();
    end
    pc_op = PC_HOLD;
    tick();
    `CHK("pc step", 16'h0006, program_counter)
    pc_target = 16'hBE7F; pc_op = PC_LOAD;
    tick();
    pc_op = PC_HOLD;
    wr(8'h00, 8'hFF);
    `CHK("pc load", 16'hBE7F, program_counter)
    opcode_in = 8'h5A; opcode_load = 1'b1;
    tick();
    opcode_load = 1'b0;
    `CHK("opcode", 8'h5A, opcode_latch)
    instr_kind = 2'd2;
    tick();
    `CHK("cyc lit", 2'd2, exec_cycles)
    instr_kind = 2'd0;
    tick();
    `CHK("cyc bank", 2'd1, exec_cycles)
    $display("flow test done");
    // Same register index in every bank holds its own byte
    for (int b = 0; b < 4; b++)
    begin
      wr(ADDR_FLAGS, 8'(b << 3));
      bank_wr = 1'b1; bank_idx = 3'd7; bank_wdata = 8'(8'hA0 + b);
      tick();
      bank_wr = 1'b0;
      tick();
    end
    for (int b = 0; b < 4; b++)
    begin
      wr(ADDR_FLAGS, 8'(b << 3));
      tick();
      `CHK("bank", 8'(8'hA0 + b), bank_rdata)
    end
    $display("bank test done");
    // Flags: ALU outcome, bit writes, parity over accumulator
    wr(ADDR_FLAGS, 8'h00);
    alu_flags = '{upd: 1'b1, carry: 1'b1, aux: 1'b0, ovf: 1'b1};
    tick();
    alu_flags = '0;
    rd(ADDR_FLAGS);
    `CHK("alu flags", 8'h84, rb)
    bit_req = '{wr: 1'b1, addr: ADDR_FLAGS, pos: 3'd5, val: 1'b1};
    tick();
    bit_req = '{wr: 1'b1, addr: ADDR_PROG_CTRL, pos: 3'd7, val: 1'b1};
    tick();
    bit_req = '0;
    rd(ADDR_FLAGS);
    `CHK("bit flags", 8'hA4, rb)
    rd(ADDR_PROG_CTRL);
    `CHK("prog ctrl", 8'h00, rb)
    wr(ADDR_PROG_CTRL, 8'h80);
    rd(ADDR_PROG_CTRL);
    `CHK("prog byte", 8'h80, rb)
    acc_wr = 1'b1; acc_wdata = 8'h07;
    tick();
    acc_wr = 1'b0;
    rd(ADDR_FLAGS);
    `CHK("parity odd", 1'b1, rb[FLAG_PARITY])
    acc_wr = 1'b1; acc_wdata = 8'hC3;
    tick();
    acc_wr = 1'b0;
    rd(ADDR_FLAGS);
    `CHK("parity even", 1'b0, rb[FLAG_PARITY])
    // Auxiliary register: operand path and scratch byte
    muldiv_wr = 1'b1; muldiv_aux_res = 8'h3C;
    tick();
    muldiv_wr = 1'b0;
    `CHK("muldiv", 8'h3C, muldiv_operand)
    wr(ADDR_MULAUX, 8'h96);
    rd(ADDR_MULAUX);
    `CHK("scratch", 8'h96, rb)
    $display("flag test done");
    // Pointer as two bytes, as one word, and main versus shadow
    wr(ADDR_PTR_LOW, 8'hFF);
    wr(ADDR_PTR_HIGH, 8'h12);
    ptr_inc = 1'b1;
    tick();
    ptr_inc = 1'b0;
    `CHK("ptr inc", 16'h1300, active_pointer)
    wr(ADDR_PTR_SEL, 8'h01);
    wr(ADDR_PTR_LOW, 8'h34);
    `CHK("shadow", 16'h0034, active_pointer)
    wr(ADDR_PTR_SEL, 8'h00);
    `CHK("main", 16'h1300, active_pointer)
    $display("pointer test done");
    // Stack wraps past the top and returns bytes in reverse order
    wr(ADDR_STACK, 8'hFF);
    stk(STK_PUSH, program_counter[7:0]);
    rd(ADDR_STACK);
    `CHK("sp wrap", 8'h00, rb)
    stk(STK_PUSH, program_counter[15:8]);
    stk(STK_POP, 8'h00);
    `CHK("pop hi", 8'hBE, stack_rdata)
    stk(STK_POP, 8'h00);
    `CHK("pop lo", 8'h7F, stack_rdata)
    rd(ADDR_STACK);
    `CHK("sp back", 8'hFF, rb)
    // Push straight into pop hands back the same byte
    stack_op = STK_PUSH; stack_wdata = 8'hA5;
    tick();
    stack_op = STK_POP;
    tick();
    stack_op = STK_NONE;
    tick();
    `CHK("lifo", 8'hA5, stack_rdata)
    rd(ADDR_STACK);
    `CHK("sp lifo", 8'hFF, rb)
    $display("stack test done");
    results();
  end

endmodule : tb_top
